// ---- design/prc_sequencer.v ----
// Summary of operation
// - Power-on input asserts all three resets together
// - Latch role, host enable, boot straps
// - Debug strap at release selects debug entry
// - External line seen only when idle; hard forces soft
// - Hard reset covers system blocks; soft keeps configuration
// - Status register records latest reset sources
// - 1024 configuration cycles, then sample clock straps
// - Wait 800 reference clocks for PLL lock
// - DLL lock 3073 bus clocks after PLL
// - DLL bypass skips DLL lock wait
// - Hard released after 512, soft three later
// - Host enable: 32-bit bus, wait host word
// - Host disabled: role low master, high slave
// - Bits 2-3 core PLL pre-divide
// - Bits 4-7 core multiplier
// - Bits 8-11 bus divide
// - Bits 12-15 comm processor divide
// - Bits 16-19 system PLL pre-divide
// - Bits 20-23 system PLL multiplier
// - Bit 25 DLL bypass, others reserved
// - Clock mode register read-only, drives clocks
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "prc_consts.vh"

module prc_sequencer (
  // Clock, reset, enable
  input wire CLK,
  input wire RST,
  input wire CE,
  // APB slave
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  // Clock ticks of the derived clocks
  input wire PLL_REF_TICK,
  input wire BUS_CLK_TICK,
  // Power-on reset and straps
  input wire POWER_ON_RESET_N,
  input wire CONFIG_ROLE_SELECT,
  input wire DEBUG_ENTRY_STRAP,
  input wire HOST_PORT_ENABLE_STRAP,
  input wire [1:0] BOOT_SOURCE_SELECT,
  input wire [2:0] CLOCK_MODE_STRAPS,
  // Open-drain reset lines, low active
  input wire HARD_RESET_LINE_N_I,
  output reg HARD_RESET_LINE_N_O,
  output reg HARD_RESET_LINE_N_OE,
  input wire SOFT_RESET_LINE_N_I,
  output reg SOFT_RESET_LINE_N_O,
  output reg SOFT_RESET_LINE_N_OE,
  // Internal reset and mode outputs
  output reg INTERNAL_POR,
  output reg HARD_RESET_ACT,
  output reg SOFT_RESET_ACT,
  output reg HOST_PORT_EN,
  output reg BUS_32BIT,
  output reg CONFIG_MASTER,
  output reg [1:0] BOOT_SOURCE,
  output reg DEBUG_ENTRY,
  output reg PLL_LOCK_EN,
  output reg CLOCKS_ENABLE,
  output reg DLL_LOCK_EN,
  output reg [31:0] SYSTEM_CLOCK_MODE
);

  localparam [2:0] S_POR = 3'd0;
  localparam [2:0] S_CONFIG = 3'd1;
  localparam [2:0] S_HOST_WAIT = 3'd2;
  localparam [2:0] S_PLL = 3'd3;
  localparam [2:0] S_DLL = 3'd4;
  localparam [2:0] S_HARD = 3'd5;
  localparam [2:0] S_SOFT = 3'd6;
  localparam [2:0] S_RUN = 3'd7;

  reg [2:0] state_reg, state_next;
  reg [11:0] count_reg, count_next;
  reg por_q_reg;
  reg role_reg, host_en_reg, debug_reg;
  reg [1:0] boot_reg;
  reg [31:0] cfg_word_reg, cfg_word_next;
  reg [2:0] cfg_bytes_reg, cfg_bytes_next;
  reg [31:0] clock_mode_reg, clock_mode_next;
  reg [2:0] status_reg, status_next;
  reg pready_reg;

  // Hardware configuration runs from a fixed word
  localparam [31:0] hw_cfg_word = `PRC_CW_HW_DEFAULT;

  wire apb_access = PSEL & PENABLE & ~pready_reg;
  wire apb_write = apb_access & PWRITE;
  wire por_rise = POWER_ON_RESET_N & ~por_q_reg;
  wire cfg_done = (cfg_bytes_reg == 3'd4);
  wire dll_bypass = host_en_reg ? cfg_word_reg[`PRC_CW_DLL_BYPASS_BIT] :
                    hw_cfg_word[`PRC_CW_DLL_BYPASS_BIT];
  wire [2:0] mode_high = host_en_reg ? cfg_word_reg[`PRC_CW_MODE_HIGH_LSB +: 3] :
                         hw_cfg_word[`PRC_CW_MODE_HIGH_LSB +: 3];
  wire driving = (state_reg != S_RUN);
  wire hard_drive = (state_reg <= S_HARD);

  // Register address match
  function reg_hit;
    input [11:0] addr;
    input [11:0] offset;
    begin
      reg_hit = (addr == offset);
    end
  endfunction

  // Six-bit clock mode to register image
  function [31:0] clock_mode_decode;
    input [5:0] mode;
    input bypass;
    reg [31:0] cm;
    begin
      cm = 32'h0000_0000;
      cm[`PRC_CM_CORE_PDF_LSB +: 2] = {1'b0, mode[2]};
      cm[`PRC_CM_CORE_MF_LSB +: 4] = mode[5] ? `PRC_CORE_MF_12 : `PRC_CORE_MF_10;
      case (mode[4:3])
        2'd0: cm[`PRC_CM_BUS_DF_LSB +: 4] = `PRC_BUS_DF_3;
        2'd1: cm[`PRC_CM_BUS_DF_LSB +: 4] = `PRC_BUS_DF_4;
        default: cm[`PRC_CM_BUS_DF_LSB +: 4] = `PRC_BUS_DF_5;
      endcase
      cm[`PRC_CM_COMM_DF_LSB +: 4] = `PRC_COMM_DF_2;
      cm[`PRC_CM_SYS_PDF_LSB +: 4] = {2'b00, mode[1:0]};
      cm[`PRC_CM_SYS_MF_LSB +: 4] = `PRC_SYS_MF_12 + {1'b0, mode[5:3]};
      cm[`PRC_CM_DLL_BYPASS_BIT] = bypass;
      clock_mode_decode = cm;
    end
  endfunction

  // Sequencer
  always @* begin
    state_next = state_reg;
    count_next = count_reg;
    case (state_reg)
      S_POR: begin
        count_next = 12'd0;
        if (por_rise) begin
          state_next = S_CONFIG;
        end
      end
      S_CONFIG: begin
        count_next = count_reg + 12'd1;
        if (count_reg == {1'b0, `PRC_CONFIG_CYCLES} - 12'd1) begin
          count_next = 12'd0;
          state_next = host_en_reg ? S_HOST_WAIT : S_PLL;
        end
      end
      S_HOST_WAIT: begin
        if (cfg_done) begin
          state_next = S_PLL;
        end
      end
      S_PLL: begin
        if (PLL_REF_TICK) begin
          count_next = count_reg + 12'd1;
          if (count_reg == `PRC_PLL_LOCK_CYCLES - 12'd1) begin
            count_next = 12'd0;
            state_next = dll_bypass ? S_HARD : S_DLL;
          end
        end
      end
      S_DLL: begin
        if (BUS_CLK_TICK) begin
          count_next = count_reg + 12'd1;
          if (count_reg == `PRC_DLL_LOCK_CYCLES - 12'd1) begin
            count_next = 12'd0;
            state_next = S_HARD;
          end
        end
      end
      S_HARD: begin
        if (BUS_CLK_TICK) begin
          count_next = count_reg + 12'd1;
          if (count_reg == `PRC_HARD_HOLD_CYCLES - 12'd1) begin
            count_next = 12'd0;
            state_next = S_SOFT;
          end
        end
      end
      S_SOFT: begin
        if (BUS_CLK_TICK) begin
          count_next = count_reg + 12'd1;
          if (count_reg == `PRC_SOFT_LAG_CYCLES - 12'd1) begin
            count_next = 12'd0;
            state_next = S_RUN;
          end
        end
      end
      S_RUN: begin
        count_next = 12'd0;
        if (!HARD_RESET_LINE_N_I) begin
          state_next = S_HARD;
        end else if (!SOFT_RESET_LINE_N_I) begin
          state_next = S_SOFT;
        end
      end
      default: begin
        state_next = S_POR;
        count_next = 12'd0;
      end
    endcase
    if (!POWER_ON_RESET_N) begin
      state_next = S_POR;
      count_next = 12'd0;
    end
  end

  // Host configuration word, status and clock mode
  always @* begin
    cfg_word_next = cfg_word_reg;
    cfg_bytes_next = cfg_bytes_reg;
    clock_mode_next = clock_mode_reg;
    status_next = status_reg;
    // four byte writes, first is most significant
    if (apb_write && reg_hit(PADDR, `PRC_OFF_HOST_CONFIG) && host_en_reg && !cfg_done &&
        state_reg != S_POR && state_reg <= S_HOST_WAIT) begin
      cfg_word_next = {cfg_word_reg[23:0], PWDATA[7:0]};
      cfg_bytes_next = cfg_bytes_reg + 3'd1;
    end
    if (por_rise) begin
      cfg_word_next = 32'h0000_0000;
      cfg_bytes_next = 3'd0;
    end
    if ((state_reg == S_CONFIG || state_reg == S_HOST_WAIT) && state_next == S_PLL) begin
      clock_mode_next = clock_mode_decode({mode_high, CLOCK_MODE_STRAPS}, dll_bypass);
    end
    // write one to clear, new cause wins
    if (apb_write && reg_hit(PADDR, `PRC_OFF_RESET_STATUS)) begin
      status_next = status_reg & ~PWDATA[2:0];
    end
    if (!POWER_ON_RESET_N) begin
      status_next = 3'b001;
    end else if (state_reg == S_RUN && !HARD_RESET_LINE_N_I) begin
      status_next = 3'b010;
    end else if (state_reg == S_RUN && !SOFT_RESET_LINE_N_I) begin
      status_next = 3'b100;
    end
  end

  always @(posedge CLK) begin
    if (RST) begin
      state_reg <= S_POR;
      count_reg <= 12'd0;
      por_q_reg <= 1'b0;
      role_reg <= 1'b0;
      host_en_reg <= 1'b0;
      debug_reg <= 1'b0;
      boot_reg <= `PRC_BOOT_EXT_MEM;
      cfg_word_reg <= 32'h0000_0000;
      cfg_bytes_reg <= 3'd0;
      clock_mode_reg <= 32'h0000_0000;
      status_reg <= 3'b000;
    end else if (CE) begin
      state_reg <= state_next;
      count_reg <= count_next;
      por_q_reg <= POWER_ON_RESET_N;
      if (por_rise) begin
        role_reg <= CONFIG_ROLE_SELECT;
        host_en_reg <= HOST_PORT_ENABLE_STRAP;
        boot_reg <= BOOT_SOURCE_SELECT;
        debug_reg <= DEBUG_ENTRY_STRAP;
      end
      cfg_word_reg <= cfg_word_next;
      cfg_bytes_reg <= cfg_bytes_next;
      clock_mode_reg <= clock_mode_next;
      status_reg <= status_next;
    end
  end

  // Registered outputs
  always @(posedge CLK) begin
    if (RST) begin
      HARD_RESET_LINE_N_O <= 1'b0;
      HARD_RESET_LINE_N_OE <= 1'b1;
      SOFT_RESET_LINE_N_O <= 1'b0;
      SOFT_RESET_LINE_N_OE <= 1'b1;
      INTERNAL_POR <= 1'b1;
      HARD_RESET_ACT <= 1'b1;
      SOFT_RESET_ACT <= 1'b1;
      HOST_PORT_EN <= 1'b0;
      BUS_32BIT <= 1'b0;
      CONFIG_MASTER <= 1'b0;
      BOOT_SOURCE <= `PRC_BOOT_EXT_MEM;
      DEBUG_ENTRY <= 1'b0;
      PLL_LOCK_EN <= 1'b0;
      CLOCKS_ENABLE <= 1'b0;
      DLL_LOCK_EN <= 1'b0;
      SYSTEM_CLOCK_MODE <= 32'h0000_0000;
    end else if (CE) begin
      // Line drivers only ever pull low
      HARD_RESET_LINE_N_O <= 1'b0;
      SOFT_RESET_LINE_N_O <= 1'b0;
      INTERNAL_POR <= (state_next <= S_HOST_WAIT);
      HARD_RESET_ACT <= (state_next <= S_HARD);
      HARD_RESET_LINE_N_OE <= (state_next <= S_HARD);
      SOFT_RESET_ACT <= (state_next != S_RUN);
      SOFT_RESET_LINE_N_OE <= (state_next != S_RUN);
      HOST_PORT_EN <= host_en_reg;
      BUS_32BIT <= host_en_reg;
      CONFIG_MASTER <= ~host_en_reg & ~role_reg;
      BOOT_SOURCE <= boot_reg;
      DEBUG_ENTRY <= debug_reg;
      PLL_LOCK_EN <= (state_next == S_PLL);
      CLOCKS_ENABLE <= (state_next >= S_DLL);
      DLL_LOCK_EN <= (state_next == S_DLL);
      SYSTEM_CLOCK_MODE <= clock_mode_next;
    end
  end

  // APB slave, one wait state
  always @(posedge CLK) begin
    if (RST) begin
      pready_reg <= 1'b0;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
    end else if (CE) begin
      // A pending answer blocks a second take
      pready_reg <= apb_access;
      PREADY <= apb_access;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
      if (apb_access) begin
        case (PADDR)
          `PRC_OFF_CLOCK_MODE: PRDATA <= clock_mode_reg;
          `PRC_OFF_RESET_STATUS: PRDATA <= {29'd0, status_reg};
          `PRC_OFF_HOST_CONFIG: PRDATA <= cfg_word_reg;
          // Bit 3 is spare and reads zero
          `PRC_OFF_SEQ_STATUS: PRDATA <= {20'd0, boot_reg, debug_reg, role_reg,
                                         host_en_reg, cfg_bytes_reg, 1'b0,
                                         state_reg};
          default: PSLVERR <= 1'b1;
        endcase
      end
    end
  end

endmodule

// ---- design/prc_consts.vh ----
`ifndef PRC_CONSTS_VH
`define PRC_CONSTS_VH

// Register byte offsets
`define PRC_OFF_CLOCK_MODE 12'h000
`define PRC_OFF_RESET_STATUS 12'h004
`define PRC_OFF_HOST_CONFIG 12'h008
`define PRC_OFF_SEQ_STATUS 12'h00c

// Clock mode register field positions
`define PRC_CM_CORE_PDF_LSB 2
`define PRC_CM_CORE_MF_LSB 4
`define PRC_CM_BUS_DF_LSB 8
`define PRC_CM_COMM_DF_LSB 12
`define PRC_CM_SYS_PDF_LSB 16
`define PRC_CM_SYS_MF_LSB 20
`define PRC_CM_DLL_BYPASS_BIT 25

// Field codes
`define PRC_CORE_MF_10 4'h5
`define PRC_CORE_MF_12 4'h6
`define PRC_BUS_DF_3 4'h2
`define PRC_BUS_DF_4 4'h3
`define PRC_BUS_DF_5 4'h4
`define PRC_COMM_DF_2 4'h1
`define PRC_SYS_MF_12 4'h6
`define PRC_BOOT_EXT_MEM 2'h0
`define PRC_BOOT_HOST 2'h1

// Configuration word field positions
`define PRC_CW_MODE_HIGH_LSB 0
`define PRC_CW_DLL_BYPASS_BIT 3
`define PRC_CW_HW_DEFAULT 32'h0000_0000

// Reset status bits
`define PRC_RS_POWER_ON 0
`define PRC_RS_EXT_HARD 1
`define PRC_RS_EXT_SOFT 2

// Sequence timing, in cycles of the named clock
`define PRC_CONFIG_CYCLES 11'd1024
`define PRC_PLL_LOCK_CYCLES 12'd800
`define PRC_DLL_LOCK_CYCLES 12'd3073
`define PRC_HARD_HOLD_CYCLES 12'd512
`define PRC_SOFT_LAG_CYCLES 12'd3

`endif

// ---- sim/prc_sequencer_assertions.sv ----
`timescale 1ns/1ps
module prc_sequencer_checker (
  input wire CLK,
  input wire RST,
  input wire POWER_ON_RESET_N,
  input wire PSEL,
  input wire PENABLE,
  input wire PREADY,
  input wire PSLVERR,
  input wire INTERNAL_POR,
  input wire HARD_RESET_ACT,
  input wire SOFT_RESET_ACT,
  input wire HARD_RESET_LINE_N_OE,
  input wire PLL_LOCK_EN,
  input wire CLOCKS_ENABLE,
  input wire DLL_LOCK_EN,
  input wire [31:0] SYSTEM_CLOCK_MODE
);
  logic [11:0] cyc;
  // Cycles spent in internal power-on reset since the input last rose
  always @(posedge CLK)
    if (RST || !POWER_ON_RESET_N) cyc <= 12'h0;
    else if (INTERNAL_POR && cyc != 12'hfff) cyc <= cyc + 12'h1;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  sequence all_reset_s;
    INTERNAL_POR && HARD_RESET_ACT && SOFT_RESET_ACT;
  endsequence
  sequence pll_start_s;
    $fell(INTERNAL_POR);
  endsequence
  chk_por_all_resets: assert property (!POWER_ON_RESET_N |=> all_reset_s)
    else $error("power-on did not assert all resets");
  chk_hard_soft: assert property (HARD_RESET_ACT |-> SOFT_RESET_ACT)
    else $error("hard reset without soft reset");
  chk_oe_drive: assert property (HARD_RESET_LINE_N_OE == HARD_RESET_ACT)
    else $error("hard line drive differs from hard reset");
  chk_soft_lag: assert property ($fell(SOFT_RESET_ACT) |-> !$past(HARD_RESET_ACT, 2))
    else $error("soft released too soon after hard");
  chk_config_len: assert property (pll_start_s |-> cyc >= 12'd1024)
    else $error("configuration period too short");
  chk_pll_after: assert property (pll_start_s |-> PLL_LOCK_EN)
    else $error("pll wait not started");
  chk_clk_enable: assert property ($rose(CLOCKS_ENABLE) |-> $past(PLL_LOCK_EN) && !PLL_LOCK_EN)
    else $error("clocks enabled outside pll lock");
  chk_dll_bypass: assert property (DLL_LOCK_EN |-> !SYSTEM_CLOCK_MODE[25] && CLOCKS_ENABLE)
    else $error("dll wait while bypassed or before pll");
  chk_cm_load: assert property ($changed(SYSTEM_CLOCK_MODE) |-> pll_start_s)
    else $error("clock mode changed outside load");
  chk_cm_reserved: assert property ((SYSTEM_CLOCK_MODE & 32'hfd00_0003) == 32'h0)
    else $error("clock mode reserved bits set");
  chk_apb_answer: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("apb answer late");
  chk_err_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
endmodule
bind prc_sequencer prc_sequencer_checker i_chk (.*);

// ---- sim/prc_reset_partner.sv ----
`timescale 1ns/1ps
module prc_reset_partner (
  input wire CLK,
  input wire host_mode,
  input wire role_hw,
  input wire por_req,
  input wire pull_hard,
  input wire pull_soft,
  input wire hard_oe,
  input wire soft_oe,
  output logic por_n,
  output wire role,
  output wire hard_n,
  output wire soft_n
);
  logic [4:0] hold = 5'd0;
  initial por_n = 1'b1;
  always @(posedge CLK)
    if (por_req) begin
      hold <= 5'd20;
      por_n <= 1'b0;
    end else if (hold != 5'd0) hold <= hold - 5'd1;
    else por_n <= 1'b1;
  assign role = host_mode | role_hw;
  // Open-drain lines with pull-up
  assign hard_n = !(hard_oe || pull_hard);
  assign soft_n = !(soft_oe || pull_soft);
endmodule

// ---- sim/power_on_reset_sequencer_tb_top.sv ----
`timescale 1ns/1ps
module power_on_reset_sequencer_tb_top;
  logic CLK = 0, RST = 1, CE = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, PLL_REF_TICK = 0, BUS_CLK_TICK = 0;
  logic DEBUG_ENTRY_STRAP = 0, HOST_PORT_ENABLE_STRAP = 0;
  logic [11:0] PADDR = 0;
  logic [31:0] PWDATA = 0, seed = 32'h568c, rd, v;
  logic [1:0] BOOT_SOURCE_SELECT = 0;
  logic [2:0] CLOCK_MODE_STRAPS = 0;
  logic por_req = 0, pull_hard = 0, pull_soft = 0, role_hw = 0, err;
  int num_errors = 0, comparisons = 0, cyc = 0, nticks = 0;
  wire POWER_ON_RESET_N, CONFIG_ROLE_SELECT, HARD_RESET_LINE_N_I, SOFT_RESET_LINE_N_I, PREADY, PSLVERR;
  wire HARD_RESET_LINE_N_O, HARD_RESET_LINE_N_OE, SOFT_RESET_LINE_N_O, SOFT_RESET_LINE_N_OE, INTERNAL_POR;
  wire HARD_RESET_ACT, SOFT_RESET_ACT, HOST_PORT_EN, BUS_32BIT, CONFIG_MASTER, DEBUG_ENTRY;
  wire PLL_LOCK_EN, CLOCKS_ENABLE, DLL_LOCK_EN;
  wire [1:0] BOOT_SOURCE;
  wire [31:0] PRDATA, SYSTEM_CLOCK_MODE;
  prc_sequencer i_dut (.*);
  prc_reset_partner i_far (.CLK(CLK), .host_mode(HOST_PORT_ENABLE_STRAP), .role_hw(role_hw), .por_req(por_req),
    .pull_hard(pull_hard), .pull_soft(pull_soft), .hard_oe(HARD_RESET_LINE_N_OE), .soft_oe(SOFT_RESET_LINE_N_OE),
    .por_n(POWER_ON_RESET_N), .role(CONFIG_ROLE_SELECT), .hard_n(HARD_RESET_LINE_N_I), .soft_n(SOFT_RESET_LINE_N_I));
  always #10 CLK = ~CLK;
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function logic [31:0] cm_exp(input logic [2:0] hi, input logic [2:0] st, input logic byp);
    return {6'h0, byp, 1'b0, 4'd6 + {1'b0, hi}, 2'h0, st[1:0], 4'h1,
      hi[1:0] == 2'h0 ? 4'h2 : hi[1:0] == 2'h1 ? 4'h3 : 4'h4, hi[2] ? 4'h6 : 4'h5, 1'b0, st[2], 2'h0};
  endfunction
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Random ticks, sequence tick count and hang guard
  always @(posedge CLK) begin
    v = rnd();
    PLL_REF_TICK <= v[0];
    BUS_CLK_TICK <= v[1] | v[2];
    if (CLOCKS_ENABLE && HARD_RESET_ACT && BUS_CLK_TICK) nticks <= nticks + 1;
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      num_errors++;
      wrap_up;
    end
  end
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK) PENABLE <= 1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
  endtask
  task pulse(input logic hard);
    @(posedge CLK);
    pull_hard <= hard;
    pull_soft <= !hard;
    repeat (4) @(posedge CLK);
    chk("ext reset", {31'h0, hard}, {31'h0, HARD_RESET_ACT});
    pull_hard <= 0;
    pull_soft <= 0;
    while (SOFT_RESET_ACT !== 1'b0) @(posedge CLK);
    apb(0, 12'h004, 0);
    chk("reset status", hard ? 2 : 4, rd);
  endtask
  task run_seq(input logic host);
    logic [31:0] w, cm;
    logic [2:0] st;
    logic dbg, role;
    w = host ? rnd() & 32'hf : 32'h0;
    st = rnd();
    dbg = rnd();
    role = host | seed[0];
    cm = cm_exp(w[2:0], st, w[3]);
    @(posedge CLK);
    HOST_PORT_ENABLE_STRAP <= host;
    BOOT_SOURCE_SELECT <= {1'b0, host};
    CLOCK_MODE_STRAPS <= st;
    DEBUG_ENTRY_STRAP <= dbg;
    role_hw <= role;
    por_req <= 1;
    @(posedge CLK) por_req <= 0;
    repeat (3) @(posedge CLK);
    chk("all resets", 3'h7, {INTERNAL_POR, HARD_RESET_ACT, SOFT_RESET_ACT});
    repeat (40) @(posedge CLK);
    pull_hard <= 1;
    repeat (3) @(posedge CLK) pull_hard <= 0;
    nticks = 0;
    if (host) begin
      repeat (1200) @(posedge CLK);
      chk("por extended", 1, {31'h0, INTERNAL_POR});
      for (int i = 3; i >= 0; i--) apb(1, 12'h008, {24'h0, w[8*i +: 8]});
    end
    while (SOFT_RESET_ACT !== 1'b0) @(posedge CLK);
    chk("tick count", w[3] ? 512 : 3585, nticks);
    chk("clock mode", cm, SYSTEM_CLOCK_MODE);
    apb(1, 12'h000, 32'hffff_ffff);
    apb(0, 12'h000, 0);
    chk("clock mode read", cm, rd);
    apb(0, 12'h00c, 0);
    chk("status straps", {20'h0, 1'b0, host, dbg, role, host, 7'h0}, rd & 32'hf80);
    chk("mode outputs", {host, dbg, !host & !role, host, host},
      {BOOT_SOURCE[0], DEBUG_ENTRY, CONFIG_MASTER, HOST_PORT_EN, BUS_32BIT});
    apb(0, 12'h004, 0);
    chk("status power on", 1, rd);
    apb(0, 12'h010, 0);
    chk("unmapped error", 1, {31'h0, err});
    pulse(1);
    chk("clock mode kept", cm, SYSTEM_CLOCK_MODE);
    pulse(0);
    $display("sequence run host=%0b done", host);
  endtask
  initial begin
    repeat (3) @(posedge CLK);
    RST <= 0;
    run_seq(0);
    run_seq(1);
    wrap_up;
  end
endmodule
